// ---- bench/drum_contacts.sv ----
// Purpose: Contact panel of the controlling program facing the drum.
// Assumes: Contacts change just after a rising clock edge.
// Notes: Momentary presses outlast the drum's input filter.
`timescale 1ns/100ps
module drum_contacts (
  input wire logic core_clk,
  output logic startIn,
  output logic jogIn,
  output logic resetIn,
  output logic [15:0] eventIn
);
  // ------------------------------------------------------------
  // Idle contacts
  // ------------------------------------------------------------
  // All contacts open at time zero
  initial begin
    startIn = 1'b0;
    jogIn = 1'b0;
    resetIn = 1'b0;
    eventIn = 16'h0000;
  end

  // ------------------------------------------------------------
  // Contact actions
  // ------------------------------------------------------------
  // Level contacts, changed together so no half state is seen
  task automatic setLevels(input logic start, input logic [15:0] ev);
    @(posedge core_clk);
    startIn <= start;
    eventIn <= ev;
  endtask

  // Press held eight cycles; presses shorter than two cycles would be lost in the filter
  task automatic tap(input logic isJog);
    @(posedge core_clk);
    if (isJog) begin
      jogIn <= 1'b1;
    end else begin
      resetIn <= 1'b1;
    end
    repeat (8) @(posedge core_clk);
    jogIn <= 1'b0;
    resetIn <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// ---- bench/masked_event_drum_sequencer_test.sv ----
// Purpose: Self-checking bench for the masked event drum.
// Assumes: One timebase unit shortened to 4 clocks.
// Notes: Registers reached over APB; contacts from the panel model.
`timescale 1ns/100ps
module masked_event_drum_sequencer_test;
  import drum_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, jogIn, resetIn, startIn, drumComplete, irq;
  logic [15:0] eventIn, discreteOut;
  int errorCnt = 0;
  int numChecks = 0;

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  masked_event_drum_sequencer #(.UNIT_CYCLES(4)) dut (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .startIn(startIn), .jogIn(jogIn),
    .resetIn(resetIn), .eventIn(eventIn), .discreteOut(discreteOut),
    .drumComplete(drumComplete), .irq(irq)
  );

  drum_contacts contacts (
    .core_clk(core_clk), .startIn(startIn), .jogIn(jogIn),
    .resetIn(resetIn), .eventIn(eventIn)
  );

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  // Verdict in one place for normal end and watchdog
  task automatic closeOut;
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Pin or flag compare, case equality so unknowns fail
  task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chkVal("pready", 32'h1, 32'(pready));
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Register read compared under a field mask
  task automatic chkReg(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
    apb(1'b0, a, 32'h0);
    chkVal("pslverr", 32'h0, 32'(rerr));
    chkVal($sformatf("reg %h", a), exp, rdata & msk);
  endtask

  // Watchdog; the whole sequence needs far fewer cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    errorCnt++;
    $display("Error watchdog expected end seen timeout");
    closeOut();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    chkReg(OFS_STATE, 32'h101, 32'h71F);
    chkReg(OFS_TIMEBASE, 32'h00A, 32'hFFFFFFFF);
    chkReg(12'h100, 32'hFFFF, 32'hFFFFFFFF);
    apb(1'b0, 12'h190, 32'h0);
    chkVal("pslverr", 32'h1, 32'(rerr));
    // program zeroes masks first; unused steps stay zero
    for (int i = 0; i < 16; i++) wr(12'h100 + 12'(4 * i), 32'h0);
    wr(12'h040, 32'h00FF);
    wr(12'h044, 32'h0F0F);
    wr(12'h048, 32'hA5A5);
    wr(12'h088, 32'h3);
    wr(12'h0C8, 32'h2);
    wr(OFS_MASKBASE, 32'h1);
    wr(12'h104, 32'h0FF0);
    wr(12'h108, 32'hFFFF);
    wr(12'h10C, 32'h00FF);
    wr(OFS_TIMEBASE, 32'h0);
    wr(OFS_CTRBASE, 32'h4);
    wr(OFS_CTRL, 32'h1);
    repeat (20) @(posedge core_clk);
    // Start off: zero-count step 1 must not advance
    chkReg(OFS_STATE, 32'h201, 32'h71F);
    chkVal("discreteOut", 32'h00F0, {16'h0, discreteOut});
    wr(12'h104, 32'hFFFF);
    repeat (3) @(posedge core_clk);
    chkVal("discreteOut", 32'h00FF, {16'h0, discreteOut});
    contacts.tap(1'b1);
    chkReg(OFS_STATE, 32'h202, 32'h71F);
    chkVal("discreteOut", 32'h0F0F, {16'h0, discreteOut});
    chkReg(12'h218, 32'h1, 32'hFFFFFFFF);
    chkReg(12'h21C, 32'h2, 32'hFFFFFFFF);
    wr(12'h218, 32'h3);
    wr(12'h210, 32'h5);
    chkReg(12'h218, 32'h3, 32'hFFFFFFFF);
    chkReg(12'h210, 32'h0, 32'hFFFFFFFF);
    contacts.tap(1'b0);
    chkReg(OFS_STATE, 32'h203, 32'h71F);
    chkReg(12'h210, 32'h0, 32'h3FFF);
    chkVal("discreteOut", 32'h00A5, {16'h0, discreteOut});
    contacts.setLevels(1'b1, 16'h0000);
    repeat (40) @(posedge core_clk);
    chkReg(OFS_STATE, 32'h203, 32'h71F);
    chkReg(12'h210, 32'h0, 32'h3FFF);
    contacts.setLevels(1'b1, 16'h0002);
    repeat (8) @(posedge core_clk);
    chkVal("early complete", 32'h0, 32'(drumComplete));
    for (int i = 0; i < 80 && drumComplete !== 1'b1; i++) @(posedge core_clk);
    chkVal("drumComplete", 32'h1, 32'(drumComplete));
    chkReg(OFS_STATE, 32'h400, 32'h700);
    chkReg(12'h210, 32'h10000, 32'h10000);
    chkReg(12'h21C, 32'h10, 32'hFFFFFFFF);
    chkVal("irq masked", 32'h0, 32'(irq));
    wr(OFS_IRQMASK, 32'h2);
    repeat (2) @(posedge core_clk);
    chkVal("irq", 32'h1, 32'(irq));
    wr(OFS_IRQSTAT, 32'h2);
    repeat (2) @(posedge core_clk);
    chkVal("irq cleared", 32'h0, 32'(irq));
    contacts.setLevels(1'b0, 16'h0000);
    contacts.tap(1'b0);
    chkVal("drumComplete", 32'h0, 32'(drumComplete));
    chkReg(OFS_STATE, 32'h203, 32'h71F);
    chkVal("discreteOut run", 32'h00A5, {16'h0, discreteOut});
    // Timebase 2 gives one timer tick per 8 clocks; event off holds the step
    wr(OFS_TIMEBASE, 32'h2);
    contacts.setLevels(1'b1, 16'h0000);
    repeat (22) @(posedge core_clk);
    chkReg(12'h214, 32'h2, 32'hFFFF);
    wr(OFS_OUTSEL, 32'h1);
    wr(OFS_CTRL, 32'h3);
    repeat (3) @(posedge core_clk);
    chkReg(12'h184, 32'h00A5, 32'hFFFFFFFF);
    chkVal("discreteOut word", 32'h0, {16'h0, discreteOut});
    closeOut();
  end
endmodule

// ---- common/drum_pkg.sv ----
// Purpose: Shared constants and types for the masked event drum.
// Assumes: 125 MHz core clock, APB with 32-bit data, 12-bit byte address.
// Notes: All offsets are byte addresses of aligned words.
package drum_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 8;
  // One timebase unit is 10 ms, so 9999 units is 99.99 s
  localparam int TB_UNIT_NS = 10000000;
  localparam int TB_UNIT_CYC = TB_UNIT_NS / CLK_NS;
  localparam logic [13:0] TB_MAX = 14'h270F;
  localparam logic [13:0] CPS_MAX = 14'h270F;

  // ------------------------------------------------------------
  // Drum geometry and reset values
  // ------------------------------------------------------------
  localparam logic [4:0] FIRST_STEP = 5'h01;
  localparam logic [4:0] LAST_STEP = 5'h10;
  localparam logic [4:0] MASK_BASE_MAX = 5'h10;
  localparam logic [6:0] CTR_BASE_MAX = 7'h7C;
  localparam logic [15:0] MASK_RST = 16'hFFFF;
  localparam logic [13:0] TB_RST = 14'h000A;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_TIMEBASE = 12'h004;
  localparam logic [11:0] OFS_MASKBASE = 12'h008;
  localparam logic [11:0] OFS_OUTSEL = 12'h00C;
  localparam logic [11:0] OFS_IRQSTAT = 12'h010;
  localparam logic [11:0] OFS_IRQMASK = 12'h014;
  localparam logic [11:0] OFS_STATE = 12'h018;
  localparam logic [11:0] OFS_CTRBASE = 12'h01C;
  localparam logic [5:0] REG_PATTERN = 6'h01;
  localparam logic [5:0] REG_CPS = 6'h02;
  localparam logic [5:0] REG_EVSEL = 6'h03;
  localparam logic [5:0] REG_MASK_LO = 6'h04;
  localparam logic [5:0] REG_MASK_HI = 6'h05;
  localparam logic [5:0] REG_WORDOUT = 6'h06;
  localparam logic [11:0] OFS_COUNTERS = 12'h200;

  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WORD = 1;
  localparam int CTR_FLAG_BIT = 16;
  localparam int IRQ_STEP = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_JOG = 2;

  typedef struct packed {
    logic [15:0] pattern;
    logic [13:0] cps;
    logic [4:0] evSel;
  } stepCfg_s;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RUN = 3'b010,
    SEQ_DONE = 3'b100
  } seqState_e;

endpackage

// ---- design/masked_event_drum_sequencer.sv ----
// Purpose: Sixteen step masked event drum with APB registers.
// Assumes: Contacts arrive asynchronously; software owns run mode.
// Notes: Outputs are refreshed every clock from pattern AND mask.
//
// How it works
// - sixteen steps, output equals pattern AND mask
// - mask words read from mask base block
// - word mode writes masked word instead
// - steps advance by time, or by time while the step event is true
// - jog rising edge advances one step
// - timer runs only while start is on
// - count holds while step event is false
// - count equal to preset count advances step
// - stop after last step until reset
// - preset step loaded on run entry, reset
// - count increments once per timebase period
// - four status counters from base index
// - preset counter writable, others read only
// - complete flag set at end, reset clears
// - mask changes apply at any time
// - outputs refreshed every clock, start ignored
// - outputs enabled in run mode while word mode is off
`timescale 1ns/100ps
module masked_event_drum_sequencer
  import drum_pkg::*;
#(
  parameter int UNIT_CYCLES = TB_UNIT_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic startIn,
  input wire logic jogIn,
  input wire logic resetIn,
  input wire logic [15:0] eventIn,
  output logic [15:0] discreteOut,
  output logic drumComplete,
  output logic irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [18:0] sync1, sync2, sync3, filt;
  logic startF, jogF, resetF, jogPrev, jogRise;
  logic [15:0] eventF;
  logic runMode, wordMode;
  logic [13:0] timebase;
  logic [4:0] maskBase, presetStep, curStep, next_step;
  logic [1:0] outSel;
  logic [6:0] ctrBase;
  logic [2:0] irqStat, irqMask, irqSet;
  stepCfg_s stepTab [16];
  logic [15:0] maskMem [32];
  logic [15:0] wordOut [4];
  seqState_e state, next_state;
  logic enter, finish;
  logic [13:0] countsInStep;
  logic [15:0] timerValue;
  logic [20:0] preCnt;
  logic [13:0] unitCnt;
  logic tick, evOk, cntMatch, timing, lastUnit;
  logic [3:0] idx;
  stepCfg_s cur;
  logic [15:0] curMask, finalWord;
  logic acc, wrEn, hit;
  logic [31:0] rdata;

  // True when the selected contact is on; zero selects no event
  function automatic logic evTrue(input logic [4:0] sel, input logic [15:0] ev);
    logic [3:0] bitSel;
    bitSel = 4'(sel - 5'h01);
    if (sel == 5'h00) begin
      return 1'b1;
    end
    return ev[bitSel];
  endfunction

  // Position of a counter index relative to the status base
  function automatic logic [6:0] ctrRel(input logic [11:0] a, input logic [6:0] base);
    logic [6:0] k;
    k = a[8:2];
    return 7'(k - base);
  endfunction

  // ------------------------------------------------------------
  // Contact synchronisers
  // ------------------------------------------------------------
  // Three stages; a bit changes only once stages two and three agree
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
      jogPrev <= 1'b0;
    end else begin
      sync1 <= {eventIn, resetIn, jogIn, startIn};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
      jogPrev <= jogF;
    end
  end

  assign startF = filt[0];
  assign jogF = filt[1];
  assign resetF = filt[2];
  assign eventF = filt[18:3];
  assign jogRise = jogF && !jogPrev;

  // ------------------------------------------------------------
  // Step lookup and masking
  // ------------------------------------------------------------
  assign idx = 4'(curStep - FIRST_STEP);
  assign cur = stepTab[idx];
  assign curMask = maskMem[5'(maskBase + {1'b0, idx})];
  // bitwise AND of pattern and mask
  assign finalWord = cur.pattern & curMask;
  assign evOk = evTrue(cur.evSel, eventF);
  // count match against counts per step
  assign cntMatch = (countsInStep == cur.cps);
  assign timing = (state == SEQ_RUN) && startF;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Reset contact outranks jog and count; a held reset keeps reloading
  always_comb begin
    next_state = state;
    next_step = curStep;
    enter = 1'b0;
    finish = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (runMode) begin
          next_state = SEQ_RUN;
          next_step = presetStep;
          enter = 1'b1;
        end
      end
      SEQ_RUN: begin
        if (!runMode) begin
          next_state = SEQ_IDLE;
        end else if (resetF) begin
          next_step = presetStep;
          enter = 1'b1;
        end else if (jogRise || (startF && cntMatch)) begin
          if (curStep == LAST_STEP) begin
            next_state = SEQ_DONE;
            finish = 1'b1;
          end else begin
            next_step = 5'(curStep + 5'h01);
            enter = 1'b1;
          end
        end
      end
      SEQ_DONE: begin
        if (!runMode) begin
          next_state = SEQ_IDLE;
        end else if (resetF) begin
          next_state = SEQ_RUN;
          next_step = presetStep;
          enter = 1'b1;
        end
      end
      default: begin
        next_state = SEQ_IDLE;
      end
    endcase
  end

  // State and current step
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= SEQ_IDLE;
      curStep <= FIRST_STEP;
    end else begin
      state <= next_state;
      curStep <= next_step;
    end
  end

  // ------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------
  // Prescaler restarts on each step so the first count is a full period
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      preCnt <= '0;
      unitCnt <= '0;
    end else if (enter || !timing) begin
      preCnt <= '0;
      unitCnt <= '0;
    end else if (preCnt == 21'(UNIT_CYCLES - 1)) begin
      preCnt <= '0;
      unitCnt <= lastUnit ? 14'h0000 : 14'(unitCnt + 14'h0001);
    end else begin
      preCnt <= 21'(preCnt + 21'h000001);
    end
  end

  // Last unit of a period; timebase 0 and 1 both tick every unit
  assign lastUnit = (14'(unitCnt + 14'h0001) >= timebase);
  assign tick = timing && !enter && (preCnt == 21'(UNIT_CYCLES - 1)) && lastUnit;

  // ------------------------------------------------------------
  // Step counters
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      countsInStep <= '0;
      timerValue <= '0;
    end else if (enter) begin
      countsInStep <= '0;
      timerValue <= '0;
    end else if (tick) begin
      timerValue <= 16'(timerValue + 16'h0001);
      if (evOk && countsInStep != CPS_MAX) begin
        countsInStep <= 14'(countsInStep + 14'h0001);
      end
    end
  end

  // Drum complete flag
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drumComplete <= 1'b0;
    end else if (finish) begin
      // set at end of last step
      drumComplete <= 1'b1;
    end else if (resetF) begin
      drumComplete <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // refreshed every clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      discreteOut <= '0;
    end else begin
      discreteOut <= (runMode && !wordMode) ? finalWord : 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        wordOut[i] <= '0;
      end
    end else if (runMode && wordMode) begin
      wordOut[outSel] <= finalWord;
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign acc = psel && penable && pready;
  assign wrEn = acc && pwrite;

  // Read decode; unmapped addresses below the counter block flag an error
  always_comb begin
    rdata = '0;
    hit = 1'b1;
    if (paddr >= OFS_COUNTERS) begin
      case (ctrRel(paddr, ctrBase))
        7'h00: rdata = {15'h0000, drumComplete, 2'b00, countsInStep};
        7'h01: rdata = {16'h0000, timerValue};
        7'h02: rdata = {27'h0000000, presetStep};
        7'h03: rdata = {27'h0000000, curStep};
        default: rdata = '0;
      endcase
    end else begin
      case (paddr[11:6])
        REG_PATTERN: rdata = {16'h0000, stepTab[paddr[5:2]].pattern};
        REG_CPS: rdata = {18'h00000, stepTab[paddr[5:2]].cps};
        REG_EVSEL: rdata = {27'h0000000, stepTab[paddr[5:2]].evSel};
        REG_MASK_LO: rdata = {16'h0000, maskMem[{1'b0, paddr[5:2]}]};
        REG_MASK_HI: rdata = {16'h0000, maskMem[{1'b1, paddr[5:2]}]};
        REG_WORDOUT: begin
          rdata = {16'h0000, wordOut[paddr[3:2]]};
          hit = (paddr[5:4] == 2'b00);
        end
        6'h00: begin
          case ({paddr[5:2], 2'b00})
            OFS_CTRL[5:0]: rdata = {30'h00000000, wordMode, runMode};
            OFS_TIMEBASE[5:0]: rdata = {18'h00000, timebase};
            OFS_MASKBASE[5:0]: rdata = {27'h0000000, maskBase};
            OFS_OUTSEL[5:0]: rdata = {30'h00000000, outSel};
            OFS_IRQSTAT[5:0]: rdata = {29'h00000000, irqStat};
            OFS_IRQMASK[5:0]: rdata = {29'h00000000, irqMask};
            OFS_STATE[5:0]: rdata = {21'h000000, state, 3'b000, curStep};
            OFS_CTRBASE[5:0]: rdata = {25'h0000000, ctrBase};
            default: hit = 1'b0;
          endcase
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // Answer registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rdata;
        pslverr <= !hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Configuration registers; out of range values are ignored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      runMode <= 1'b0;
      wordMode <= 1'b0;
      timebase <= TB_RST;
      maskBase <= '0;
      outSel <= '0;
      ctrBase <= '0;
      irqMask <= '0;
    end else if (wrEn && paddr[11:6] == 6'h00) begin
      case ({paddr[5:2], 2'b00})
        OFS_CTRL[5:0]: begin
          runMode <= pwdata[CTRL_RUN];
          wordMode <= pwdata[CTRL_WORD];
        end
        OFS_TIMEBASE[5:0]: begin
          if (pwdata[13:0] <= TB_MAX && pwdata[31:14] == '0) timebase <= pwdata[13:0];
        end
        OFS_MASKBASE[5:0]: begin
          if (pwdata[4:0] <= MASK_BASE_MAX && pwdata[31:5] == '0) maskBase <= pwdata[4:0];
        end
        OFS_OUTSEL[5:0]: outSel <= pwdata[1:0];
        OFS_IRQMASK[5:0]: irqMask <= pwdata[2:0];
        OFS_CTRBASE[5:0]: begin
          if (pwdata[6:0] <= CTR_BASE_MAX && pwdata[31:7] == '0) ctrBase <= pwdata[6:0];
        end
        default: ;
      endcase
    end
  end

  // only the preset counter accepts writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presetStep <= FIRST_STEP;
    end else if (wrEn && paddr >= OFS_COUNTERS && ctrRel(paddr, ctrBase) == 7'h02) begin
      if (pwdata[4:0] >= FIRST_STEP && pwdata[4:0] <= LAST_STEP && pwdata[31:5] == '0) begin
        presetStep <= pwdata[4:0];
      end
    end
  end

  // Step table; reset leaves every step unused
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        stepTab[i] <= '0;
      end
    end else if (wrEn) begin
      case (paddr[11:6])
        REG_PATTERN: stepTab[paddr[5:2]].pattern <= pwdata[15:0];
        REG_CPS: begin
          if (pwdata[13:0] <= CPS_MAX) stepTab[paddr[5:2]].cps <= pwdata[13:0];
        end
        REG_EVSEL: begin
          if (pwdata[4:0] <= 5'h10) stepTab[paddr[5:2]].evSel <= pwdata[4:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        maskMem[i] <= MASK_RST;
      end
    end else if (wrEn && (paddr[11:6] == REG_MASK_LO || paddr[11:6] == REG_MASK_HI)) begin
      maskMem[{paddr[6], paddr[5:2]}] <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  assign irqSet = {jogRise, finish, enter};

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat <= '0;
      irq <= 1'b0;
    end else begin
      if (wrEn && paddr == OFS_IRQSTAT) begin
        irqStat <= (irqStat & ~pwdata[2:0]) | irqSet;
      end else begin
        irqStat <= irqStat | irqSet;
      end
      irq <= |(irqStat & irqMask);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_out_masked:
    assert property (discreteOut == 16'h0000 || (discreteOut & ~$past(curMask)) == 16'h0000)
    else $error("output bit set where mask is clear");

  chk_word_quiet:
    assert property (runMode && wordMode |=> discreteOut == 16'h0000)
    else $error("discrete outputs driven in word mode");

  chk_jog_advance:
    assert property (state == SEQ_RUN && runMode && !resetF && jogRise && curStep != LAST_STEP
      |=> curStep == 5'($past(curStep) + 5'h01))
    else $error("jog edge did not advance step");

  chk_start_hold:
    assert property (!startF && !enter |=> $stable(timerValue) && $stable(countsInStep))
    else $error("timer moved without start");

  chk_event_hold:
    assert property (!evOk && !enter |=> $stable(countsInStep))
    else $error("count moved while event false");

  chk_count_match:
    assert property (state == SEQ_RUN && runMode && !resetF && startF && cntMatch
      && curStep != LAST_STEP |=> curStep == 5'($past(curStep) + 5'h01))
    else $error("count match did not advance step");

  chk_done_stop:
    assert property (state == SEQ_DONE && runMode && !resetF |=> state == SEQ_DONE && $stable(curStep))
    else $error("drum left done without reset");

  chk_reset_preset:
    assert property (resetF && runMode && state != SEQ_IDLE |=> curStep == $past(presetStep))
    else $error("reset did not load preset step");

  chk_done_flag:
    assert property (finish |=> drumComplete ##1 (drumComplete || $past(resetF)))
    else $error("complete flag not set at end of drum");

  chk_entry_clear:
    assert property (enter |=> countsInStep == 14'h0000 && timerValue == 16'h0000)
    else $error("step entry left counters nonzero");

  chk_irq_level:
    assert property (|(irqStat & irqMask) |=> irq)
    else $error("interrupt not raised for unmasked status");

endmodule
